// file: acp_pkg.sv
package acp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIV = 8'h04;
  localparam logic [7:0] OFF_TUNE48 = 8'h08;
  localparam logic [7:0] OFF_TUNE441 = 8'h0c;
  // control register fields
  localparam int CTRL_XTAL_LSB = 0;
  localparam int CTRL_EN48_BIT = 4;
  localparam int CTRL_EN441_BIT = 5;
  localparam int CTRL_FAM_BIT = 6;
  localparam int CTRL_MODE128_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h01;
  // tune register fields
  localparam int TUNE_PPM_LSB = 0;
  localparam int TUNE_ACT_LSB = 8;
  localparam int TUNE_MANUAL_BIT = 31;
  localparam logic [1:0] ACT_NOP = 2'h0;
  localparam logic [1:0] ACT_FASTER = 2'h1;
  localparam logic [1:0] ACT_SLOWER = 2'h2;
  localparam logic [1:0] ACT_AUTO = 2'h3;
  // synthesizer targets and trim window
  localparam longint unsigned FOUT48_HZ = 64'd196608000;
  localparam longint unsigned FOUT441_HZ = 64'd180633600;
  localparam logic [6:0] PPM_MAX = 7'h64;
  localparam int PPM_SHIFT = 40;
  localparam logic [63:0] PPM_RECIP = 64'h10c6f8;
  localparam logic [3:0] POST_DIV48 = 4'h2;
  localparam logic [3:0] POST_DIV441 = 4'h4;
  // crystal table, indexed by the crystal select code
  localparam int XTAL_CODES = 15;
  localparam logic [3:0] XTAL_LAST = 4'he;
  localparam int unsigned XTAL_FIN_HZ [XTAL_CODES] = '{
    10000000, 12500000, 13000000, 9600000, 10000000, 13000000, 9600000,
    8832000, 8000000, 14318000, 12000000, 13000000, 12000000, 13500000, 12000000};
  localparam logic [2:0] XTAL_PREDIV [XTAL_CODES] = '{
    3'h4, 3'h2, 3'h1, 3'h2, 3'h2, 3'h2, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1,
    3'h4, 3'h4, 3'h2, 3'h2};

  // ratio word: [23:16] integer, [15:13] coarse_fraction, [12:0] fine_fraction
  function automatic logic [23:0] acp_ratio_word(input longint unsigned foutHz,
                                                 input longint unsigned finHz);
    longint unsigned q;
    q = (foutHz * 64'd65536 + finHz / 64'd2) / finHz;
    return q[23:0];
  endfunction : acp_ratio_word
endpackage : acp_pkg

// file: acp_synth_chan.sv
`timescale 1ns/1ns
module acp_synth_chan (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // configuration
  input wire logic enable,
  input wire logic refTick,
  input wire logic [23:0] nominal,
  // tuning command
  input wire logic cmdValid,
  input wire logic [6:0] cmdPpm,
  input wire logic [1:0] cmdAction,
  // status and loop control
  output logic manual,
  output logic [23:0] word,
  output logic [7:0] loopMod
);
  logic manualReg, manualNext;
  logic signed [15:0] offsetReg, offsetNext;
  logic [15:0] accReg, accNext;
  logic [7:0] loopModReg, loopModNext;
  logic [6:0] ppmClamped;
  logic [63:0] deltaProd, limitProd;
  logic signed [16:0] delta, limit, sum;
  logic carry;

  always_comb begin
    ppmClamped = (cmdPpm > acp_pkg::PPM_MAX) ? acp_pkg::PPM_MAX : cmdPpm;
    // ppm scaling by a fixed reciprocal avoids a runtime divide by one million
    deltaProd = 64'(nominal) * 64'(ppmClamped) * acp_pkg::PPM_RECIP;
    limitProd = 64'(nominal) * 64'(acp_pkg::PPM_MAX) * acp_pkg::PPM_RECIP;
    delta = {2'b00, deltaProd[acp_pkg::PPM_SHIFT +: 15]};
    limit = {2'b00, limitProd[acp_pkg::PPM_SHIFT +: 15]};
    manualNext = manualReg;
    offsetNext = offsetReg;
    sum = 17'sd0;
    if (cmdValid) begin
      unique case (cmdAction)
        acp_pkg::ACT_FASTER: begin
          manualNext = 1'b1;
          sum = {offsetReg[15], offsetReg} + delta;
          offsetNext = (sum > limit) ? limit[15:0] : sum[15:0];
        end
        acp_pkg::ACT_SLOWER: begin
          manualNext = 1'b1;
          sum = {offsetReg[15], offsetReg} - delta;
          offsetNext = (sum < -limit) ? 16'(-limit) : sum[15:0];
        end
        acp_pkg::ACT_AUTO: begin
          manualNext = 1'b0;
          offsetNext = 16'sd0;
        end
        acp_pkg::ACT_NOP: begin
        end
      endcase
    end
    // one offset step is one fine_fraction lsb, i.e. f_in / 65536
    word = manualReg ? nominal + {{8{offsetReg[15]}}, offsetReg} : nominal;
    // first-order dither between N and N+1 gives the fractional average
    {carry, accNext} = {1'b0, accReg} + {1'b0, word[15:0]};
    loopModNext = loopModReg;
    if (!enable) begin
      accNext = 16'h0000;
      loopModNext = 8'h00;
    end else if (refTick) begin
      loopModNext = word[23:16] + {7'h00, carry};
    end else begin
      accNext = accReg;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      manualReg <= 1'b0;
      offsetReg <= 16'sd0;
      accReg <= 16'h0000;
      loopModReg <= 8'h00;
    end else begin
      manualReg <= manualNext;
      offsetReg <= offsetNext;
      accReg <= accNext;
      loopModReg <= loopModNext;
    end
  end

  assign manual = manualReg;
  assign loopMod = loopModReg;

  AST_AUTO_NOMINAL: assert property (@(posedge clock) disable iff (!reset_n)
    !manualReg |-> word == nominal) else $error("auto mode word differs from nominal");
  AST_TRIM_WINDOW: assert property (@(posedge clock) disable iff (!reset_n)
    $signed({offsetReg[15], offsetReg}) <= limit && $signed({offsetReg[15], offsetReg}) >= -limit)
    else $error("trim offset outside window");
  AST_AUTO_CMD: assert property (@(posedge clock) disable iff (!reset_n)
    cmdValid && cmdAction == acp_pkg::ACT_AUTO |=> !manualReg && offsetReg == 16'sd0)
    else $error("auto command did not restore auto mode");
  AST_DITHER: assert property (@(posedge clock) disable iff (!reset_n)
    enable && refTick |=> loopModReg == $past(word[23:16])
      || loopModReg == $past(word[23:16]) + 8'h01)
    else $error("loop modulus is neither N nor N+1");
endmodule : acp_synth_chan

// file: acp_audio_pll_ctrl.sv
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
// Overview of operation
// - Pre-divide crystal by 4, 2 or 1
// - Ratio is integer plus coarse/8 plus fine/65536
// - One fine step moves output f_in/65536
// - Auto mode derives nominal 196.608/180.6336 MHz settings
// - Manual trim allowed within plus/minus 100 ppm
// - 44.1k clock from its synth, 48k likewise
// - Software picks synth family by sample rate
// - Output divider gives 256 or 128 fs
// - Tune command: ppm plus faster/slower/auto action
module acp_audio_pll_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reference and synthesizer control
  output logic refTick,
  output logic pllEn48,
  output logic pllEn441,
  output logic [7:0] loopMod48,
  output logic [7:0] loopMod441,
  // sample clock divider
  output logic sampleSrc44k1,
  output logic sampleMode128,
  output logic [12:0] sampleDivisor
);
  logic [7:0] ctrlReg, ctrlNext;
  logic [7:0] divReg, divNext;
  logic [31:0] prdataReg, prdataNext;
  logic preadyReg, preadyNext;
  logic pslverrReg, pslverrNext;
  logic [2:0] refCntReg, refCntNext;
  logic refTickReg, refTickNext;
  logic pllEn48Reg, pllEn48Next;
  logic pllEn441Reg, pllEn441Next;
  logic srcReg, srcNext;
  logic mode128Reg, mode128Next;
  logic [12:0] sdivReg, sdivNext;

  logic access, complete, wrDone, mapped;
  logic cmd48, cmd441;
  logic [3:0] xtalSel;
  logic [2:0] preDiv;
  logic [23:0] nom48, nom441, word48, word441;
  logic manual48, manual441;
  logic [23:0] nomTab48 [acp_pkg::XTAL_CODES];
  logic [23:0] nomTab441 [acp_pkg::XTAL_CODES];
  logic [3:0] postDiv;
  logic [8:0] fsDiv;

  // constant tables, folded at elaboration
  for (genvar g = 0; g < acp_pkg::XTAL_CODES; g++) begin : g_nom
    assign nomTab48[g] = acp_pkg::acp_ratio_word(acp_pkg::FOUT48_HZ,
      64'(acp_pkg::XTAL_FIN_HZ[g]));
    assign nomTab441[g] = acp_pkg::acp_ratio_word(acp_pkg::FOUT441_HZ,
      64'(acp_pkg::XTAL_FIN_HZ[g]));
  end

  // apb decode; one wait state so read data comes from a flop
  always_comb begin
    access = psel && penable;
    complete = access && preadyReg;
    wrDone = complete && pwrite;
    mapped = paddr == acp_pkg::OFF_CTRL || paddr == acp_pkg::OFF_DIV
      || paddr == acp_pkg::OFF_TUNE48 || paddr == acp_pkg::OFF_TUNE441;
    cmd48 = wrDone && paddr == acp_pkg::OFF_TUNE48;
    cmd441 = wrDone && paddr == acp_pkg::OFF_TUNE441;
    preadyNext = access && !preadyReg;
    pslverrNext = access && !preadyReg && !mapped;
    prdataNext = prdataReg;
    if (access && !preadyReg) begin
      unique case (paddr)
        acp_pkg::OFF_CTRL: prdataNext = {24'h000000, ctrlReg};
        acp_pkg::OFF_DIV: prdataNext = {24'h000000, divReg};
        acp_pkg::OFF_TUNE48: prdataNext = {manual48, 7'h00, word48};
        acp_pkg::OFF_TUNE441: prdataNext = {manual441, 7'h00, word441};
        default: prdataNext = 32'h00000000;
      endcase
    end
    ctrlNext = ctrlReg;
    divNext = divReg;
    if (wrDone && paddr == acp_pkg::OFF_CTRL) begin
      ctrlNext = pwdata[7:0];
    end
    if (wrDone && paddr == acp_pkg::OFF_DIV) begin
      divNext = pwdata[7:0];
    end
  end

  // crystal pre-divider as a reference tick enable
  always_comb begin
    xtalSel = ctrlReg[acp_pkg::CTRL_XTAL_LSB +: 4];
    // unlisted code falls back to the first crystal rather than a zero divider
    if (xtalSel > acp_pkg::XTAL_LAST) begin
      xtalSel = 4'h0;
    end
    preDiv = acp_pkg::XTAL_PREDIV[xtalSel];
    nom48 = nomTab48[xtalSel];
    nom441 = nomTab441[xtalSel];
    refTickNext = refCntReg >= preDiv - 3'h1;
    refCntNext = refTickNext ? 3'h0 : refCntReg + 3'h1;
  end

  // enables, family select and sample divider
  always_comb begin
    pllEn48Next = ctrlReg[acp_pkg::CTRL_EN48_BIT];
    pllEn441Next = ctrlReg[acp_pkg::CTRL_EN441_BIT];
    srcNext = ctrlReg[acp_pkg::CTRL_FAM_BIT];
    mode128Next = ctrlReg[acp_pkg::CTRL_MODE128_BIT];
    // 44.1k family clock is vco/4, 48k family clock is vco/2
    postDiv = srcNext ? acp_pkg::POST_DIV441 : acp_pkg::POST_DIV48;
    // half the rate for 128 fs means twice the division from the same source
    fsDiv = mode128Next ? {divReg, 1'b0} : {1'b0, divReg};
    // factors widened first, a 9-bit product would wrap for large divisors
    sdivNext = 13'(postDiv) * 13'(fsDiv);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrlReg <= acp_pkg::CTRL_RESET;
      divReg <= acp_pkg::DIV_RESET;
      prdataReg <= 32'h00000000;
      preadyReg <= 1'b0;
      pslverrReg <= 1'b0;
      refCntReg <= 3'h0;
      refTickReg <= 1'b0;
      pllEn48Reg <= 1'b0;
      pllEn441Reg <= 1'b0;
      srcReg <= 1'b0;
      mode128Reg <= 1'b0;
      sdivReg <= 13'h0000;
    end else begin
      ctrlReg <= ctrlNext;
      divReg <= divNext;
      prdataReg <= prdataNext;
      preadyReg <= preadyNext;
      pslverrReg <= pslverrNext;
      refCntReg <= refCntNext;
      refTickReg <= refTickNext;
      pllEn48Reg <= pllEn48Next;
      pllEn441Reg <= pllEn441Next;
      srcReg <= srcNext;
      mode128Reg <= mode128Next;
      sdivReg <= sdivNext;
    end
  end

  acp_synth_chan u_synth48 (
    .clock(clock),
    .reset_n(reset_n),
    .enable(pllEn48Reg),
    .refTick(refTickReg),
    .nominal(nom48),
    .cmdValid(cmd48),
    .cmdPpm(pwdata[acp_pkg::TUNE_PPM_LSB +: 7]),
    .cmdAction(pwdata[acp_pkg::TUNE_ACT_LSB +: 2]),
    .manual(manual48),
    .word(word48),
    .loopMod(loopMod48)
  );

  acp_synth_chan u_synth441 (
    .clock(clock),
    .reset_n(reset_n),
    .enable(pllEn441Reg),
    .refTick(refTickReg),
    .nominal(nom441),
    .cmdValid(cmd441),
    .cmdPpm(pwdata[acp_pkg::TUNE_PPM_LSB +: 7]),
    .cmdAction(pwdata[acp_pkg::TUNE_ACT_LSB +: 2]),
    .manual(manual441),
    .word(word441),
    .loopMod(loopMod441)
  );

  assign prdata = prdataReg;
  assign pready = preadyReg;
  assign pslverr = pslverrReg;
  assign refTick = refTickReg;
  assign pllEn48 = pllEn48Reg;
  assign pllEn441 = pllEn441Reg;
  assign sampleSrc44k1 = srcReg;
  assign sampleMode128 = mode128Reg;
  assign sampleDivisor = sdivReg;

  AST_PREDIV_COUNT: assert property (@(posedge clock) disable iff (!reset_n)
    refTickReg |-> $past(refCntReg) >= $past(preDiv) - 3'h1)
    else $error("reference tick before pre-divider count");
  AST_APB_WAIT: assert property (@(posedge clock) disable iff (!reset_n)
    psel && penable && !preadyReg |=> preadyReg)
    else $error("apb access not answered after one wait state");
  AST_FAMILY_SEL: assert property (@(posedge clock) disable iff (!reset_n)
    wrDone && paddr == acp_pkg::OFF_CTRL |=> ##1 srcReg == $past(pwdata[acp_pkg::CTRL_FAM_BIT], 2))
    else $error("family select did not follow control write");
  AST_SAMPLE_DIV: assert property (@(posedge clock) disable iff (!reset_n)
    $stable(ctrlReg) && $stable(divReg) |=> sdivReg ==
      13'(srcReg ? acp_pkg::POST_DIV441 : acp_pkg::POST_DIV48)
      * (mode128Reg ? {4'h0, $past(divReg), 1'b0} : {5'h00, $past(divReg)}))
    else $error("sample divisor mismatch");
  // a held request must not see a second ready, or it would complete twice
  AST_READY_PULSE: assert property (@(posedge clock) disable iff (!reset_n)
    preadyReg |=> !preadyReg)
    else $error("ready stood for more than one cycle");
  AST_ERR_WITH_READY: assert property (@(posedge clock) disable iff (!reset_n)
    pslverrReg |-> preadyReg)
    else $error("error response without ready");
  AST_PREDIV_ONE: assert property (@(posedge clock) disable iff (!reset_n)
    $past(preDiv) == 3'h1 |-> refTickReg)
    else $error("divide-by-one reference missed a tick");
  AST_LOOP_IDLE48: assert property (@(posedge clock) disable iff (!reset_n)
    !pllEn48Reg |=> loopMod48 == 8'h00)
    else $error("disabled synthesizer kept a loop modulus");
  AST_LOOP_IDLE441: assert property (@(posedge clock) disable iff (!reset_n)
    !pllEn441Reg |=> loopMod441 == 8'h00)
    else $error("disabled synthesizer kept a loop modulus");
endmodule : acp_audio_pll_ctrl

// file: tb.sv
`timescale 1ns/1ns
module tb;
  // clock and reset
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  // apb master
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // synthesizer and divider outputs
  logic refTick;
  logic pllEn48;
  logic pllEn441;
  logic [7:0] loopMod48;
  logic [7:0] loopMod441;
  logic sampleSrc44k1;
  logic sampleMode128;
  logic [12:0] sampleDivisor;
  int miscompares = 0;
  int samplesChecked = 0;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [31:0] rng = 32'd10506;

  acp_audio_pll_ctrl uut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refTick(refTick), .pllEn48(pllEn48), .pllEn441(pllEn441),
    .loopMod48(loopMod48), .loopMod441(loopMod441), .sampleSrc44k1(sampleSrc44k1),
    .sampleMode128(sampleMode128), .sampleDivisor(sampleDivisor));

  initial begin
    forever #25 clock = ~clock;
  end

  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // rounded auto ratio, kept apart from the design's own arithmetic
  function automatic logic [23:0] autoWord(input longint unsigned fo, input longint unsigned fi);
    return 24'((fo * 64'd65536 + fi / 64'd2) / fi);
  endfunction : autoWord

  function automatic longint dlt(input logic [23:0] nom, input int p);
    longint unsigned t;
    t = 64'(nom) * 64'((p > 100) ? 100 : p) * acp_pkg::PPM_RECIP;
    return longint'(t >> acp_pkg::PPM_SHIFT);
  endfunction : dlt

  // one transfer; the expected answer is noted before the request goes out
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] exp);
    int n;
    notes.push_back({~wr, err, exp});
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // gap in cycles between two reference ticks
  task automatic tickGap(input int exp);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (refTick !== 1'b1 && n < 20);
    if (refTick !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (refTick !== 1'b1 && n < 20);
    if (refTick !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    chk(32'(n), 32'(exp));
  endtask : tickGap

  // answer watcher: settled values, half a cycle before the sampling edge
  always @(negedge clock) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        chk(32'h0, 32'h1);
      end else begin
        note = notes.pop_front();
        chk(32'(pslverr), 32'(note[32]));
        if (note[33]) begin
          chk(prdata, note[31:0]);
        end
      end
    end
  end

  initial begin
    int idx;
    int p;
    logic [7:0] a;
    logic [7:0] c;
    logic [23:0] nom;
    longint off;
    longint lim;
    logic man;
    logic [31:0] sum;
    logic [1:0] acts [7];
    int ppms [7];
    acts = '{acp_pkg::ACT_FASTER, acp_pkg::ACT_FASTER, acp_pkg::ACT_SLOWER, acp_pkg::ACT_SLOWER,
             acp_pkg::ACT_SLOWER, acp_pkg::ACT_NOP, acp_pkg::ACT_AUTO};
    ppms = '{-1, 127, -1, 127, 100, 5, 0};
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    apb(0, acp_pkg::OFF_CTRL, 0, 0, 32'h0);
    apb(0, acp_pkg::OFF_DIV, 0, 0, 32'h1);
    apb(0, acp_pkg::OFF_TUNE48, 0, 0, 32'(autoWord(acp_pkg::FOUT48_HZ, 10000000)));
    for (int k = 0; k < 16; k++) begin
      idx = (k == 15) ? 0 : k;
      apb(1, acp_pkg::OFF_CTRL, 32'(k) | 32'h30, 0, 0);
      repeat (8) @(posedge clock);
      tickGap(int'(acp_pkg::XTAL_PREDIV[idx]));
      apb(0, acp_pkg::OFF_TUNE48, 0, 0,
          32'(autoWord(acp_pkg::FOUT48_HZ, acp_pkg::XTAL_FIN_HZ[idx])));
      apb(0, acp_pkg::OFF_TUNE441, 0, 0,
          32'(autoWord(acp_pkg::FOUT441_HZ, acp_pkg::XTAL_FIN_HZ[idx])));
    end
    // crystal code 15 runs as code 0 from here on
    for (int ch = 0; ch < 2; ch++) begin
      a = ch ? acp_pkg::OFF_TUNE441 : acp_pkg::OFF_TUNE48;
      nom = autoWord(ch ? acp_pkg::FOUT441_HZ : acp_pkg::FOUT48_HZ, 10000000);
      lim = dlt(nom, 100);
      off = 0;
      man = 1'b0;
      for (int k = 0; k < 7; k++) begin
        rng = xs(rng);
        p = (ppms[k] < 0) ? int'(rng % 101) : ppms[k];
        apb(1, a, {22'h0, acts[k], 1'b0, 7'(p)}, 0, 0);
        case (acts[k])
          acp_pkg::ACT_FASTER: begin
            off += dlt(nom, p);
            man = 1'b1;
          end
          acp_pkg::ACT_SLOWER: begin
            off -= dlt(nom, p);
            man = 1'b1;
          end
          acp_pkg::ACT_AUTO: begin
            off = 0;
            man = 1'b0;
          end
          default: ;
        endcase
        off = (off > lim) ? lim : ((off < -lim) ? -lim : off);
        apb(0, a, 0, 0, {man, 7'h0, 24'(longint'(nom) + off)});
      end
    end
    apb(0, 8'h10, 0, 1, 32'h0);
    apb(1, 8'h14, 32'hff, 1, 32'h0);
    for (int m = 0; m < 4; m++) begin
      rng = xs(rng);
      c = {m[1:0], m[0], ~m[0], 4'h2};
      apb(1, acp_pkg::OFF_DIV, {24'h0, rng[7:0]}, 0, 0);
      apb(1, acp_pkg::OFF_CTRL, {24'h0, c}, 0, 0);
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk(32'({sampleMode128, sampleSrc44k1, pllEn441, pllEn48}), 32'(c[7:4]));
      chk(32'(sampleDivisor), 32'(13'((m[0] ? 4 : 2) * (m[1] ? 2 : 1) * rng[7:0])));
      chk(32'(m[0] ? loopMod48 : loopMod441), 32'h0);
    end
    // divide-by-one reference: one tick per cycle, a full accumulator lap sums to the word
    apb(1, acp_pkg::OFF_CTRL, 32'h12, 0, 0);
    repeat (8) @(posedge clock);
    sum = 32'h0;
    repeat (65536) begin
      @(negedge clock);
      sum += 32'(loopMod48);
    end
    chk(sum, 32'(autoWord(acp_pkg::FOUT48_HZ, 13000000)));
    end_of_test();
  end
endmodule : tb
